// ### move_pkg.sv
// constants, types and helpers shared by the data-move decode and execute logic
// How it works
// - opcode E5 plus direct address loads the accumulator; two bytes, one cycle.
// - loading the accumulator from its own direct address is flagged invalid.
// - opcode 74 plus constant loads the accumulator; two bytes, one cycle.
// - opcodes F8-FF copy the accumulator into a bank register; one byte, one cycle.
// - opcodes A8-AF load a bank register from a direct address; two bytes, two cycles.
// - opcodes 78-7F load a constant into a bank register; two bytes, one cycle.
// - opcode F5 stores the accumulator to a direct address; two bytes, one cycle.
// - opcodes 88-8F store a bank register to a direct address; two bytes, two cycles.
// - opcode 85 moves direct to direct, source address first; three bytes, two cycles.
// - opcode 86/87 stores an indirect byte to a direct address; two bytes, two cycles.
// - opcode 75 stores a constant to a direct address; three bytes, two cycles.
// - opcode A6/A7 writes a direct byte to the indirect target; two bytes, two cycles.
// - opcode 76/77 writes a constant to the indirect target; two bytes, one cycle.
// - every bit move has the carry as one operand and copies source into destination.
// - a bit move changes only its destination bit.
// - opcode A3 plus bit address copies that bit into carry; two bytes, one cycle.
// - opcode 92 plus bit address writes carry into that bit; two bytes, two cycles.
// - every byte move keeps its source and touches only the destination.
`default_nettype none
package move_pkg;

	// ------------------------------------------------------------------
	// widths and addresses
	// ------------------------------------------------------------------
	localparam int unsigned BANK_W = 2;
	localparam int unsigned REG_W = 3;
	localparam int unsigned PAD_W = 8 - BANK_W - REG_W;
	typedef logic [7:0] byte_type;
	typedef logic [BANK_W-1:0] bank_type;
	localparam byte_type ACC_ADDR = 8'hE0;
	localparam byte_type ACC_RESET = 8'h00;
	localparam byte_type BIT_AREA_BASE = 8'h20;

	// ------------------------------------------------------------------
	// opcodes and masks
	// ------------------------------------------------------------------
	localparam byte_type MASK_FULL = 8'hFF;
	localparam byte_type MASK_PTR = 8'hFE;
	localparam byte_type MASK_REG = 8'hF8;
	localparam byte_type OP_A_DIR = 8'hE5;
	localparam byte_type OP_A_IND = 8'hE6;
	localparam byte_type OP_A_IMM = 8'h74;
	localparam byte_type OP_R_A = 8'hF8;
	localparam byte_type OP_R_DIR = 8'hA8;
	localparam byte_type OP_R_IMM = 8'h78;
	localparam byte_type OP_DIR_A = 8'hF5;
	localparam byte_type OP_DIR_R = 8'h88;
	localparam byte_type OP_DIR_DIR = 8'h85;
	localparam byte_type OP_DIR_IND = 8'h86;
	localparam byte_type OP_DIR_IMM = 8'h75;
	localparam byte_type OP_IND_A = 8'hF6;
	localparam byte_type OP_IND_DIR = 8'hA6;
	localparam byte_type OP_IND_IMM = 8'h76;
	localparam byte_type OP_C_BIT = 8'hA3;
	localparam byte_type OP_BIT_C = 8'h92;

	localparam logic [1:0] LEN1 = 2'h1;
	localparam logic [1:0] LEN2 = 2'h2;
	localparam logic [1:0] LEN3 = 2'h3;
	localparam logic [1:0] CYC1 = 2'h1;
	localparam logic [1:0] CYC2 = 2'h2;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [7:0] {
		OPD_NONE = 8'h01,
		OPD_ACC = 8'h02,
		OPD_IMM = 8'h04,
		OPD_DIR = 8'h08,
		OPD_REG = 8'h10,
		OPD_IND = 8'h20,
		OPD_CARRY = 8'h40,
		OPD_BIT = 8'h80
	} opd_type;

	typedef enum logic [8:0] {
		ST_OPCODE = 9'h001,
		ST_OPERAND = 9'h002,
		ST_PTR_RD = 9'h004,
		ST_PTR_CAP = 9'h008,
		ST_SRC_RD = 9'h010,
		ST_SRC_CAP = 9'h020,
		ST_DST_RD = 9'h040,
		ST_DST_CAP = 9'h080,
		ST_WRITE = 9'h100
	} state_type;

	typedef struct packed {
		logic valid;
		opd_type src;
		opd_type dst;
		logic [1:0] len;
		logic [1:0] cycles;
		logic imm_in_b2;
		logic dst_in_b2;
		logic [REG_W-1:0] reg_sel;
		logic ptr_sel;
	} decode_type;

	typedef struct packed {
		logic valid;
		byte_type data;
	} fetch_type;

	typedef struct packed {
		logic en;
		byte_type addr;
		byte_type data;
	} mem_wr_type;

	typedef struct packed {
		state_type st;
		byte_type op;
		byte_type b1;
		byte_type b2;
		logic [1:0] cnt;
		byte_type ptr;
		byte_type src;
		byte_type dbyte;
		byte_type acc;
		logic carry;
		logic req;
		byte_type rd_addr;
		logic rd_acc;
		mem_wr_type wr;
		logic busy;
		logic done;
		logic invalid;
		logic unsup;
		logic [1:0] len;
		logic [1:0] cyc;
	} core_state_type;

	localparam core_state_type CORE_RESET = '{st: ST_OPCODE, acc: ACC_RESET, req: 1'b1, default: '0};

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic opmatch(input byte_type op, input byte_type pat, input byte_type mask);
		opmatch = ((op & mask) == pat);
	endfunction

	function automatic byte_type reg_addr(input bank_type bank, input logic [REG_W-1:0] r);
		reg_addr = {{PAD_W{1'b0}}, bank, r};
	endfunction

endpackage
`default_nettype wire

// ### move_decode.sv
// opcode decoder for the byte and bit move group
`timescale 1ns/1ps
`default_nettype none
module move_decode (
	input wire move_pkg::byte_type op_in,
	output move_pkg::decode_type dec_out
);
	import move_pkg::*;

	function automatic decode_type mk(input opd_type s, input opd_type t, input logic [1:0] l, input logic [1:0] c);
		mk = '0;
		mk.valid = 1'b1;
		mk.src = s;
		mk.dst = t;
		mk.len = l;
		mk.cycles = c;
	endfunction

	decode_type dec;

	always_comb begin
		dec = '0;
		dec.src = OPD_NONE;
		dec.dst = OPD_NONE;
		if (opmatch(op_in, OP_A_DIR, MASK_FULL)) begin
			dec = mk(OPD_DIR, OPD_ACC, LEN2, CYC1);
		end else if (opmatch(op_in, OP_A_IND, MASK_PTR)) begin
			dec = mk(OPD_IND, OPD_ACC, LEN1, CYC1);
		end else if (opmatch(op_in, OP_A_IMM, MASK_FULL)) begin
			dec = mk(OPD_IMM, OPD_ACC, LEN2, CYC1);
		end else if (opmatch(op_in, OP_R_A, MASK_REG)) begin
			dec = mk(OPD_ACC, OPD_REG, LEN1, CYC1);
		end else if (opmatch(op_in, OP_R_DIR, MASK_REG)) begin
			dec = mk(OPD_DIR, OPD_REG, LEN2, CYC2);
		end else if (opmatch(op_in, OP_R_IMM, MASK_REG)) begin
			dec = mk(OPD_IMM, OPD_REG, LEN2, CYC1);
		end else if (opmatch(op_in, OP_DIR_A, MASK_FULL)) begin
			dec = mk(OPD_ACC, OPD_DIR, LEN2, CYC1);
		end else if (opmatch(op_in, OP_DIR_R, MASK_REG)) begin
			dec = mk(OPD_REG, OPD_DIR, LEN2, CYC2);
		end else if (opmatch(op_in, OP_DIR_DIR, MASK_FULL)) begin
			dec = mk(OPD_DIR, OPD_DIR, LEN3, CYC2);
			dec.dst_in_b2 = 1'b1;
		end else if (opmatch(op_in, OP_DIR_IND, MASK_PTR)) begin
			dec = mk(OPD_IND, OPD_DIR, LEN2, CYC2);
		end else if (opmatch(op_in, OP_DIR_IMM, MASK_FULL)) begin
			dec = mk(OPD_IMM, OPD_DIR, LEN3, CYC2);
			dec.imm_in_b2 = 1'b1;
		end else if (opmatch(op_in, OP_IND_DIR, MASK_PTR)) begin
			dec = mk(OPD_DIR, OPD_IND, LEN2, CYC2);
		end else if (opmatch(op_in, OP_IND_IMM, MASK_PTR)) begin
			dec = mk(OPD_IMM, OPD_IND, LEN2, CYC1);
		end else if (opmatch(op_in, OP_IND_A, MASK_PTR)) begin
			dec = mk(OPD_ACC, OPD_IND, LEN1, CYC1);
		end else if (opmatch(op_in, OP_C_BIT, MASK_FULL)) begin
			dec = mk(OPD_BIT, OPD_CARRY, LEN2, CYC1);
		end else if (opmatch(op_in, OP_BIT_C, MASK_FULL)) begin
			dec = mk(OPD_CARRY, OPD_BIT, LEN2, CYC2);
		end
		dec.reg_sel = op_in[REG_W-1:0];
		dec.ptr_sel = op_in[0];
	end

	assign dec_out = dec;

endmodule // move_decode
`default_nettype wire

// ### bit_locate.sv
// maps a bit address to the byte that holds it and the bit position inside
`timescale 1ns/1ps
`default_nettype none
module bit_locate (
	input wire move_pkg::byte_type bit_addr_in,
	output move_pkg::byte_type byte_addr_out,
	output logic [2:0] bit_idx_out
);
	import move_pkg::*;

	// low half lives in the bit-addressable ram area, high half in register bytes on 8-byte boundaries
	always_comb begin
		if (bit_addr_in[7]) begin
			byte_addr_out = {bit_addr_in[7:3], 3'h0};
		end else begin
			byte_addr_out = BIT_AREA_BASE + {4'h0, bit_addr_in[6:3]};
		end
		bit_idx_out = bit_addr_in[2:0];
	end

endmodule // bit_locate
`default_nettype wire

// ### byte_bit_move_decode.sv
// fetch, decode and execute of the byte and bit move instructions
`timescale 1ns/1ps
`default_nettype none
module byte_bit_move_decode (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire move_pkg::fetch_type fetch_in,
	input wire move_pkg::bank_type bank_sel_in,
	input wire move_pkg::byte_type mem_rd_data_in,
	output logic fetch_req_out,
	output move_pkg::byte_type mem_rd_addr_out,
	output move_pkg::mem_wr_type mem_wr_out,
	output move_pkg::byte_type acc_out,
	output logic carry_out,
	output logic busy_out,
	output logic done_out,
	output logic invalid_out,
	output logic unsupported_out,
	output logic [1:0] instr_len_out,
	output logic [1:0] instr_cycles_out
);
	import move_pkg::*;

	core_state_type q;
	core_state_type d;
	decode_type dec;
	byte_type bit_byte;
	logic [2:0] bit_idx;
	byte_type rd_val;
	byte_type imm;
	byte_type dst_dir;
	byte_type new_byte;
	byte_type src_addr;
	logic [1:0] oper_cnt;

	// ------------------------------------------------------------------
	// decode and bit addressing
	// ------------------------------------------------------------------
	move_decode u_decode (
		.op_in(q.op),
		.dec_out(dec)
	);

	bit_locate u_bit (
		.bit_addr_in(q.b1),
		.byte_addr_out(bit_byte),
		.bit_idx_out(bit_idx)
	);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		d.wr.en = 1'b0;
		d.done = 1'b0;
		d.invalid = 1'b0;
		d.unsup = 1'b0;
		oper_cnt = dec.len - LEN1;
		// the accumulator has a direct address of its own, so reads there bypass memory
		rd_val = q.rd_acc ? q.acc : mem_rd_data_in;
		imm = dec.imm_in_b2 ? q.b2 : q.b1;
		dst_dir = dec.dst_in_b2 ? q.b2 : q.b1;
		new_byte = q.dbyte;
		new_byte[bit_idx] = q.src[0];
		src_addr = q.b1;
		unique case (q.st)
			ST_OPCODE: begin
				if (q.req && fetch_in.valid) begin
					d.op = fetch_in.data;
					d.cnt = 2'h0;
					d.req = 1'b0;
					d.st = ST_OPERAND;
				end
			end
			ST_OPERAND: begin
				if (!dec.valid) begin
					// not a move: report and hand control back after the opcode byte
					d.unsup = 1'b1;
					d.done = 1'b1;
					d.len = LEN1;
					d.cyc = CYC1;
					d.req = 1'b1;
					d.st = ST_OPCODE;
				end else if (q.req && fetch_in.valid) begin
					if (q.cnt == 2'h0) begin
						d.b1 = fetch_in.data;
					end else begin
						d.b2 = fetch_in.data;
					end
					d.cnt = q.cnt + 2'h1;
					d.req = 1'b0;
				end else if (q.cnt < oper_cnt) begin
					d.req = 1'b1;
				end else if (dec.src == OPD_IND || dec.dst == OPD_IND) begin
					d.st = ST_PTR_RD;
				end else begin
					d.st = ST_SRC_RD;
				end
			end
			ST_PTR_RD: begin
				d.rd_addr = reg_addr(bank_sel_in, {2'h0, dec.ptr_sel});
				d.rd_acc = 1'b0;
				d.st = ST_PTR_CAP;
			end
			ST_PTR_CAP: begin
				d.ptr = mem_rd_data_in;
				d.st = ST_SRC_RD;
			end
			ST_SRC_RD: begin
				d.st = (dec.dst == OPD_BIT) ? ST_DST_RD : ST_WRITE;
				case (dec.src)
					OPD_ACC: begin
						d.src = q.acc;
					end
					OPD_IMM: begin
						d.src = imm;
					end
					OPD_CARRY: begin
						d.src = {7'h00, q.carry};
					end
					OPD_DIR, OPD_REG, OPD_IND, OPD_BIT: begin
						if (dec.src == OPD_REG) begin
							src_addr = reg_addr(bank_sel_in, dec.reg_sel);
						end else if (dec.src == OPD_IND) begin
							src_addr = q.ptr;
						end else if (dec.src == OPD_BIT) begin
							src_addr = bit_byte;
						end
						d.rd_addr = src_addr;
						d.rd_acc = (dec.src != OPD_REG && dec.src != OPD_IND) && (src_addr == ACC_ADDR);
						d.st = ST_SRC_CAP;
					end
					default: begin
						d.src = q.src;
					end
				endcase
			end
			ST_SRC_CAP: begin
				if (dec.src == OPD_BIT) begin
					d.src = {7'h00, rd_val[bit_idx]};
				end else begin
					d.src = rd_val;
				end
				d.st = (dec.dst == OPD_BIT) ? ST_DST_RD : ST_WRITE;
			end
			ST_DST_RD: begin
				// the byte holding the target bit is read first so its other bits survive
				d.rd_addr = bit_byte;
				d.rd_acc = (bit_byte == ACC_ADDR);
				d.st = ST_DST_CAP;
			end
			ST_DST_CAP: begin
				d.dbyte = rd_val;
				d.st = ST_WRITE;
			end
			ST_WRITE: begin
				case (dec.dst)
					OPD_ACC: begin
						d.acc = q.src;
					end
					OPD_CARRY: begin
						d.carry = q.src[0];
					end
					OPD_REG: begin
						d.wr = '{en: 1'b1, addr: reg_addr(bank_sel_in, dec.reg_sel), data: q.src};
					end
					OPD_IND: begin
						d.wr = '{en: 1'b1, addr: q.ptr, data: q.src};
					end
					OPD_DIR: begin
						if (dst_dir == ACC_ADDR) begin
							d.acc = q.src;
						end else begin
							d.wr = '{en: 1'b1, addr: dst_dir, data: q.src};
						end
					end
					OPD_BIT: begin
						if (bit_byte == ACC_ADDR) begin
							d.acc = new_byte;
						end else begin
							d.wr = '{en: 1'b1, addr: bit_byte, data: new_byte};
						end
					end
					default: begin
						d.acc = q.acc;
					end
				endcase
				// accumulator loaded from its own address has no defined meaning; it is flagged only
				d.invalid = (q.op == OP_A_DIR) && (q.b1 == ACC_ADDR);
				d.done = 1'b1;
				d.len = dec.len;
				d.cyc = dec.cycles;
				d.req = 1'b1;
				d.st = ST_OPCODE;
			end
		endcase
		d.busy = (d.st != ST_OPCODE);
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			q <= CORE_RESET;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign fetch_req_out = q.req;
	assign mem_rd_addr_out = q.rd_addr;
	assign mem_wr_out = q.wr;
	assign acc_out = q.acc;
	assign carry_out = q.carry;
	assign busy_out = q.busy;
	assign done_out = q.done;
	assign invalid_out = q.invalid;
	assign unsupported_out = q.unsup;
	assign instr_len_out = q.len;
	assign instr_cycles_out = q.cyc;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	acc_direct_len_a: assert property (done_out && q.op == OP_A_DIR |-> instr_len_out == LEN2 && instr_cycles_out == CYC1)
		else $error("direct accumulator load has wrong length or cycles");
	self_load_flag_a: assert property (done_out && q.op == OP_A_DIR && q.b1 == ACC_ADDR |-> invalid_out)
		else $error("accumulator self load not flagged");
	indirect_load_len_a: assert property (done_out && (q.op & MASK_PTR) == OP_A_IND |-> instr_len_out == LEN1)
		else $error("indirect accumulator load has wrong length");
	imm_acc_load_a: assert property (q.st == ST_WRITE && q.op == OP_A_IMM |=> acc_out == $past(q.b1))
		else $error("immediate not loaded into accumulator");
	acc_to_reg_a: assert property (q.st == ST_WRITE && (q.op & MASK_REG) == OP_R_A
		|=> mem_wr_out.en && mem_wr_out.addr == reg_addr($past(bank_sel_in), $past(q.op[REG_W-1:0]))
		&& mem_wr_out.data == acc_out)
		else $error("accumulator not copied to chosen bank register");
	acc_store_dir_a: assert property (q.st == ST_WRITE && q.op == OP_DIR_A && q.b1 != ACC_ADDR
		|=> mem_wr_out.en && mem_wr_out.addr == $past(q.b1) && mem_wr_out.data == acc_out)
		else $error("accumulator not stored to direct address");
	dir_dir_order_a: assert property (q.st == ST_WRITE && q.op == OP_DIR_DIR && q.b2 != ACC_ADDR
		|=> mem_wr_out.en && mem_wr_out.addr == $past(q.b2))
		else $error("direct move wrote to the source address");
	dir_imm_len_a: assert property (done_out && q.op == OP_DIR_IMM |-> instr_len_out == LEN3 && instr_cycles_out == CYC2)
		else $error("direct immediate store has wrong length or cycles");
	bit_to_carry_a: assert property (q.st == ST_WRITE && q.op == OP_C_BIT
		|=> carry_out == $past(q.src[0]) && $stable(acc_out) && !mem_wr_out.en)
		else $error("bit to carry move wrong or disturbed other state");
	carry_to_bit_a: assert property (q.st == ST_WRITE && q.op == OP_BIT_C && bit_byte != ACC_ADDR
		|=> mem_wr_out.data == ($past(q.dbyte) & ~(8'h01 << $past(bit_idx))
		| ({7'h00, carry_out} << $past(bit_idx))) && $stable(carry_out))
		else $error("carry to bit move changed other bits");
	source_kept_a: assert property (q.st == ST_WRITE && (dec.dst == OPD_REG || dec.dst == OPD_IND)
		|=> $stable(acc_out) && $stable(carry_out))
		else $error("byte move disturbed accumulator or carry");
	pointer_select_a: assert property (q.st == ST_PTR_RD
		|=> mem_rd_addr_out == reg_addr($past(bank_sel_in), {2'h0, $past(q.op[0])}))
		else $error("wrong pointer register read");
	done_bounded_a: assert property (q.st == ST_SRC_RD |-> ##[1:4] done_out)
		else $error("execution did not complete");
	fetch_drop_a: assert property (fetch_req_out && fetch_in.valid
		|=> !fetch_req_out)
		else $error("request held after take");
	done_pulse_a: assert property (done_out
		|=> !done_out)
		else $error("done too long");
	write_done_a: assert property (mem_wr_out.en
		|-> done_out && !busy_out)
		else $error("write outside completion");
	unsup_len_a: assert property (unsupported_out
		|-> done_out
		&& instr_len_out == LEN1
		&& instr_cycles_out == CYC1)
		else $error("bad unsupported length");
	dir_src_rd_a: assert property (q.st == ST_SRC_CAP
		&& dec.src == OPD_DIR
		|-> mem_rd_addr_out == q.b1)
		else $error("bad direct source address");
	reg_dir_wr_a: assert property (q.st == ST_WRITE
		&& (q.op & MASK_REG) == OP_R_DIR
		|=> mem_wr_out.en
		&& mem_wr_out.addr == reg_addr($past(bank_sel_in), $past(q.op[REG_W-1:0])))
		else $error("bad register load target");
	reg_imm_wr_a: assert property (q.st == ST_WRITE
		&& (q.op & MASK_REG) == OP_R_IMM
		|=> mem_wr_out.en
		&& mem_wr_out.data == $past(q.b1))
		else $error("bad register constant");
	reg_store_rd_a: assert property (q.st == ST_SRC_CAP
		&& (q.op & MASK_REG) == OP_DIR_R
		|-> mem_rd_addr_out == reg_addr(bank_sel_in, q.op[REG_W-1:0]))
		else $error("bad register store source");
	ind_src_rd_a: assert property (q.st == ST_SRC_CAP
		&& dec.src == OPD_IND
		|-> mem_rd_addr_out == q.ptr)
		else $error("bad indirect source address");
	ind_dst_wr_a: assert property (q.st == ST_WRITE
		&& dec.dst == OPD_IND
		|=> mem_wr_out.en
		&& mem_wr_out.addr == $past(q.ptr))
		else $error("bad indirect target");
	ind_acc_wr_a: assert property (q.st == ST_WRITE
		&& (q.op & MASK_PTR) == OP_IND_A
		|=> mem_wr_out.data == acc_out)
		else $error("bad indirect store data");
	ind_imm_wr_a: assert property (q.st == ST_WRITE
		&& (q.op & MASK_PTR) == OP_IND_IMM
		|=> mem_wr_out.data == $past(q.b1))
		else $error("bad indirect constant");
	carry_src_a: assert property (q.st == ST_SRC_RD
		&& q.op == OP_BIT_C
		|=> q.src[0] == $past(carry_out))
		else $error("carry not taken as source");
	bit_src_rd_a: assert property (q.st == ST_SRC_CAP
		&& q.op == OP_C_BIT
		|-> mem_rd_addr_out == bit_byte)
		else $error("bad bit source address");
	rmw_read_a: assert property (q.st == ST_DST_CAP
		|-> mem_rd_addr_out == bit_byte)
		else $error("bad bit byte address");
	slow_len_a: assert property (done_out
		&& ((q.op & MASK_REG) == OP_R_DIR
		|| (q.op & MASK_REG) == OP_DIR_R
		|| (q.op & MASK_PTR) == OP_DIR_IND
		|| (q.op & MASK_PTR) == OP_IND_DIR
		|| q.op == OP_BIT_C)
		|-> instr_len_out == LEN2
		&& instr_cycles_out == CYC2)
		else $error("bad two cycle length");
	fast_len_a: assert property (done_out
		&& ((q.op & MASK_REG) == OP_R_IMM
		|| (q.op & MASK_PTR) == OP_IND_IMM
		|| q.op == OP_C_BIT
		|| q.op == OP_DIR_A
		|| q.op == OP_A_IMM)
		|-> instr_len_out == LEN2
		&& instr_cycles_out == CYC1)
		else $error("bad one cycle length");
	one_byte_len_a: assert property (done_out
		&& ((q.op & MASK_REG) == OP_R_A
		|| (q.op & MASK_PTR) == OP_IND_A)
		|-> instr_len_out == LEN1
		&& instr_cycles_out == CYC1)
		else $error("bad one byte length");

	dir_dir_cover_c: cover property (done_out && q.op == OP_DIR_DIR);
	ind_dir_cover_c: cover property (done_out && (q.op & MASK_PTR) == OP_IND_DIR);
	carry_bit_cover_c: cover property (done_out && q.op == OP_BIT_C);
	invalid_cover_c: cover property (invalid_out);
	unsup_cover_c: cover property (unsupported_out);

endmodule // byte_bit_move_decode
`default_nettype wire

// ### tb.sv
// self-checking testbench for the byte and bit move decode and execute block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import move_pkg::*;

	// ----------------------------------------------------------------
	// design hookup and internal memory model
	// ----------------------------------------------------------------
	logic core_clk_in;
	logic rst_n_in;
	fetch_type fetch_in;
	bank_type bank_sel_in;
	byte_type mem_rd_data_in;
	logic fetch_req_out;
	byte_type mem_rd_addr_out;
	mem_wr_type mem_wr_out;
	byte_type acc_out;
	logic carry_out;
	logic busy_out;
	logic done_out;
	logic invalid_out;
	logic unsupported_out;
	logic [1:0] instr_len_out;
	logic [1:0] instr_cycles_out;
	byte_type mem [256];
	int mismatches;
	int samples_checked;
	int wr_cnt;
	int wr_base;
	logic [1:0] d_len;
	logic [1:0] d_cyc;
	logic d_inv;
	logic d_uns;

	byte_bit_move_decode uut (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.fetch_in(fetch_in),
		.bank_sel_in(bank_sel_in),
		.mem_rd_data_in(mem_rd_data_in),
		.fetch_req_out(fetch_req_out),
		.mem_rd_addr_out(mem_rd_addr_out),
		.mem_wr_out(mem_wr_out),
		.acc_out(acc_out),
		.carry_out(carry_out),
		.busy_out(busy_out),
		.done_out(done_out),
		.invalid_out(invalid_out),
		.unsupported_out(unsupported_out),
		.instr_len_out(instr_len_out),
		.instr_cycles_out(instr_cycles_out)
	);

	// memory answers in the same cycle the address is shown
	assign mem_rd_data_in = mem[mem_rd_addr_out];

	always @(posedge core_clk_in) begin
		if (mem_wr_out.en === 1'b1) begin
			mem[mem_wr_out.addr] <= mem_wr_out.data;
			wr_cnt <= wr_cnt + 1;
		end
	end

	initial begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic hang(input string name);
		mismatches++;
		$display("BAD %s expected handshake seen none", name);
		stop_test();
	endtask

	// every task is entered and left 1 ns after a rising edge
	task automatic send_byte(input byte_type b);
		int i;
		i = 0;
		while (fetch_req_out !== 1'b1) begin
			@(posedge core_clk_in);
			#1;
			i++;
			if (i > 40) hang("fetch_req");
		end
		fetch_in.valid = 1'b1;
		fetch_in.data = b;
		@(posedge core_clk_in);
		#1;
		fetch_in.valid = 1'b0;
		fetch_in.data = ~b;
	endtask

	// one instruction; the edge after done lets the memory write land
	task automatic op(input byte_type o, input byte_type b1, input byte_type b2, input int n);
		int i;
		wr_base = wr_cnt;
		send_byte(o);
		chk("busy", busy_out, 1'b1);
		if (n > 1) send_byte(b1);
		if (n > 2) send_byte(b2);
		i = 0;
		while (done_out !== 1'b1) begin
			@(posedge core_clk_in);
			#1;
			i++;
			if (i > 40) hang("done");
		end
		d_len = instr_len_out;
		d_cyc = instr_cycles_out;
		d_inv = invalid_out;
		d_uns = unsupported_out;
		@(posedge core_clk_in);
		#1;
	endtask

	function automatic logic [7:0] writes();
		return 8'(wr_cnt - wr_base);
	endfunction

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk("reset", {fetch_req_out, busy_out, carry_out, done_out}, 8'h08);
		chk("reset_acc", acc_out, ACC_RESET);
	endtask

	task automatic t_acc_loads();
		op(OP_A_IMM, 8'h5A, 8'h00, 2);
		chk("a_imm", acc_out, 8'h5A);
		chk("a_imm_lc", {d_len, d_cyc}, {LEN2, CYC1});
		mem[8'h30] = 8'hC3;
		op(OP_A_DIR, 8'h30, 8'h00, 2);
		chk("a_dir", acc_out, 8'hC3);
		chk("a_dir_lc", {d_inv, d_len, d_cyc}, {1'b0, LEN2, CYC1});
		chk("a_dir_src", mem[8'h30], 8'hC3);
		chk("a_dir_wr", writes(), 8'h00);
		op(OP_A_DIR, ACC_ADDR, 8'h00, 2);
		chk("a_self_inv", d_inv, 1'b1);
		chk("a_self_acc", acc_out, 8'hC3);
	endtask

	task automatic t_bank_regs();
		bank_sel_in = 2'h1;
		for (int r = 0; r < 8; r++) begin
			op(OP_R_IMM | 8'(r), 8'h90 + 8'(r), 8'h00, 2);
			chk("r_imm", mem[8'h08 + 8'(r)], 8'h90 + 8'(r));
			chk("r_imm_lc", {d_len, d_cyc}, {LEN2, CYC1});
			chk("r_imm_wr", writes(), 8'h01);
		end
		op(OP_R_A | 8'h2, 8'h00, 8'h00, 1);
		chk("r_a", mem[8'h0A], 8'hC3);
		chk("r_a_lc", {d_len, d_cyc}, {LEN1, CYC1});
		op(OP_DIR_A, 8'h40, 8'h00, 2);
		chk("dir_a", mem[8'h40], 8'hC3);
		chk("dir_a_lc", {d_len, d_cyc}, {LEN2, CYC1});
		mem[8'h41] = 8'h3C;
		op(OP_R_DIR | 8'h3, 8'h41, 8'h00, 2);
		chk("r_dir", mem[8'h0B], 8'h3C);
		chk("r_dir_lc", {d_len, d_cyc}, {LEN2, CYC2});
		op(OP_DIR_R | 8'h7, 8'h50, 8'h00, 2);
		chk("dir_r", mem[8'h50], 8'h97);
		chk("dir_r_lc", {d_len, d_cyc}, {LEN2, CYC2});
		bank_sel_in = 2'h0;
		op(OP_R_A | 8'h2, 8'h00, 8'h00, 1);
		chk("r_a_bank0", mem[8'h02], 8'hC3);
		chk("r_a_bank1", mem[8'h0A], 8'hC3);
	endtask

	task automatic t_direct();
		mem[8'h31] = 8'hA5;
		mem[8'h60] = 8'h00;
		op(OP_DIR_DIR, 8'h31, 8'h60, 3);
		chk("dd", mem[8'h60], 8'hA5);
		chk("dd_src", mem[8'h31], 8'hA5);
		chk("dd_lc", {d_len, d_cyc}, {LEN3, CYC2});
		op(OP_DIR_IMM, 8'h61, 8'h77, 3);
		chk("d_imm", mem[8'h61], 8'h77);
		chk("d_imm_lc", {d_len, d_cyc}, {LEN3, CYC2});
	endtask

	task automatic t_indirect();
		bank_sel_in = 2'h2;
		mem[8'h10] = 8'h70;
		mem[8'h11] = 8'h71;
		mem[8'h71] = 8'h6E;
		op(OP_A_IND | 8'h1, 8'h00, 8'h00, 1);
		chk("a_ind", acc_out, 8'h6E);
		chk("a_ind_lc", {d_len, d_cyc}, {LEN1, CYC1});
		op(OP_IND_A, 8'h00, 8'h00, 1);
		chk("ind_a", mem[8'h70], 8'h6E);
		chk("ind_a_lc", {d_len, d_cyc}, {LEN1, CYC1});
		op(OP_DIR_IND | 8'h1, 8'h62, 8'h00, 2);
		chk("d_ind", mem[8'h62], 8'h6E);
		chk("d_ind_lc", {d_len, d_cyc}, {LEN2, CYC2});
		op(OP_IND_DIR, 8'h61, 8'h00, 2);
		chk("ind_d", mem[8'h70], 8'h77);
		chk("ind_d_lc", {d_len, d_cyc}, {LEN2, CYC2});
		op(OP_IND_IMM | 8'h1, 8'hB4, 8'h00, 2);
		chk("ind_imm", mem[8'h71], 8'hB4);
		chk("ind_imm_r0", mem[8'h70], 8'h77);
		chk("ind_imm_lc", {d_len, d_cyc}, {LEN2, CYC1});
	endtask

	task automatic t_bits();
		mem[8'h21] = 8'h08;
		mem[8'h20] = 8'hFE;
		op(OP_C_BIT, 8'h0B, 8'h00, 2);
		chk("c_bit", carry_out, 1'b1);
		chk("c_bit_lc", {d_len, d_cyc}, {LEN2, CYC1});
		chk("c_bit_wr", writes(), 8'h00);
		op(OP_BIT_C, 8'h0C, 8'h00, 2);
		chk("bit_c", mem[8'h21], 8'h18);
		chk("bit_c_lc", {d_len, d_cyc}, {LEN2, CYC2});
		chk("bit_c_keep", acc_out, 8'h6E);
		chk("bit_c_keepc", carry_out, 1'b1);
		op(OP_C_BIT, 8'h00, 8'h00, 2);
		chk("c_bit0", carry_out, 1'b0);
		op(OP_BIT_C, 8'h0F, 8'h00, 2);
		chk("bit_c0", mem[8'h21], 8'h18);
		chk("bit_c0_wr", writes(), 8'h01);
	endtask

	task automatic t_other();
		op(8'h00, 8'h00, 8'h00, 1);
		chk("unsup", {d_uns, d_len, d_cyc}, {1'b1, LEN1, CYC1});
		chk("unsup_wr", writes(), 8'h00);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n_in = 1'b0;
		fetch_in = '0;
		bank_sel_in = 2'h0;
		mismatches = 0;
		samples_checked = 0;
		wr_cnt = 0;
		for (int a = 0; a < 256; a++) mem[a] = 8'(a) ^ 8'h5A;
		repeat (6) @(posedge core_clk_in);
		#1;
		rst_n_in = 1'b1;
		t_reset();
		t_acc_loads();
		t_bank_regs();
		t_direct();
		t_indirect();
		op(OP_A_IMM, 8'h6E, 8'h00, 2);
		t_bits();
		t_other();
		stop_test();
	end
endmodule // tb
`default_nettype wire
